// ### design/fcs_sequencer.sv
// command decoder and embedded program/erase control for main and secondary flash
module fcs_sequencer
  import fcs_pkg::*;
// Contract
// - main flash has eight sectors, secondary four 8 KB sectors, each selected
// - per-sector protection; program or erase of protected sector refused
// - erase whole sectors or whole memory only; program one byte each time
// - suspended erase allows other-sector reads, and resumes later
// - ready/busy low while program or erase runs, high otherwise
// - main select routes to main unless a secondary select is also active; any secondary select routes to secondary
// - plain writes never change flash; only program or erase sequences do
// - bytes decoded in order; executed only if each gap is below time-out
// - invalid byte or inter-byte time-out returns to read-array mode; in bypass the code returns to bypass mode instead
// - commands start AA at 555 then 55 at AAA
// - address bits 15..12 ignored; a target sector select must be active
// - unlock, 90 at 555, read at x01 returns main identifier
// - unlock, 90 at 555, read at x02 returns 01 protected, 00 not
// - unlock, A0 at 555, then data write programs target address
// - unlock, 80, unlock, 30 at sector; more 30 writes add sectors
// - unlock, 80, unlock, 10 at 555 erases whole memory; code marks unprotected sectors of selected flash but never clears the array
// - B0 suspends running sector erase; 30 resumes suspended erase
// - F0 at any address resets decoder to read-array; the code ignores F0 in bypass mode and while busy
// - bypass: unlock then 20; A0 plus data programs; 90 then 00 exits
// - program address taken at strobe fall, data at strobe rise
// - extra sector addresses within 80 us; afterwards the erase starts
// - toggle status bit inverts on each read while operation runs
// - data poll bit reads complement of programmed bit until done
#(
  parameter int TIMEOUT_CYC = CMD_TIMEOUT_CYC,
  parameter int ADD_SECTOR_WIN_CYC = ADD_SECTOR_CYC,
  parameter int ERASE_CYC = ERASE_SECTOR_CYC,
  parameter logic [7:0] MAIN_ID = MAIN_ID_DEFAULT // arbitrary value
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic wr_strobe_b,
  input wire logic rd_strobe_b,
  input wire logic [MAIN_SECTORS-1:0] main_sector_select,
  input wire logic [SEC_SECTORS-1:0] secondary_sector_select,
  input wire logic [MAIN_SECTORS-1:0] main_protect,
  input wire logic [SEC_SECTORS-1:0] secondary_protect,
  output logic [DATA_W-1:0] bus_rdata,
  output logic ready_busy,
  output logic error_flag
);
  // ==========================================
  // pin synchronisers
  logic [1:0] wr_s1_q, wr_s2_q, rd_s1_q, rd_s2_q;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [DATA_W-1:0] data_s1_q, data_s2_q;
  logic [MAIN_SECTORS-1:0] fs_s1_q, fs_s2_q;
  logic [SEC_SECTORS-1:0] cs_s1_q, cs_s2_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_s1_q <= 2'h3;
      wr_s2_q <= 2'h3;
      rd_s1_q <= 2'h3;
      rd_s2_q <= 2'h3;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      fs_s1_q <= '0;
      fs_s2_q <= '0;
      cs_s1_q <= '0;
      cs_s2_q <= '0;
    end else begin
      wr_s1_q <= {wr_s1_q[0], wr_strobe_b};
      wr_s2_q <= {wr_s2_q[0], wr_s1_q[1]};
      rd_s1_q <= {rd_s1_q[0], rd_strobe_b};
      rd_s2_q <= {rd_s2_q[0], rd_s1_q[1]};
      addr_s1_q <= bus_addr;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= bus_wdata;
      data_s2_q <= data_s1_q;
      fs_s1_q <= main_sector_select;
      fs_s2_q <= fs_s1_q;
      cs_s1_q <= secondary_sector_select;
      cs_s2_q <= cs_s1_q;
    end
  end

  // strobe edges from the synchronised history
  logic wr_fall, wr_rise, rd_fall;
  assign wr_fall = wr_s2_q[1] && !wr_s2_q[0];
  assign wr_rise = !wr_s2_q[1] && wr_s2_q[0];
  assign rd_fall = rd_s2_q[1] && !rd_s2_q[0];

  // ==========================================
  // sector routing
  logic main_sel, sec_sel, any_sel;
  logic [2:0] main_idx;
  logic [1:0] sec_idx;
  assign main_sel = |fs_s2_q;
  assign sec_sel = |cs_s2_q;
  assign any_sel = main_sel || sec_sel;

  always_comb begin
    main_idx = '0;
    sec_idx = '0;
    for (int i = 0; i < MAIN_SECTORS; i++) begin
      if (fs_s2_q[i]) begin
        main_idx = 3'(i);
      end
    end
    for (int i = 0; i < SEC_SECTORS; i++) begin
      if (cs_s2_q[i]) begin
        sec_idx = 2'(i);
      end
    end
  end

  // ==========================================
  // state
  typedef struct packed {
    fcs_state_type st;
    fcs_state_type ret;
    logic bypass;
    logic [MEM_AW-1:0] pa;
    logic [DATA_W-1:0] pd;
    logic [MAIN_SECTORS-1:0] main_erase;
    logic [SEC_SECTORS-1:0] sec_erase;
    logic bulk;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] gap;
    logic [3:0] cursor;
    logic toggle;
    logic err;
    logic [DATA_W-1:0] rdata;
    logic rd_pend;
    logic rd_status;
  } fcs_regs_type;

  fcs_regs_type r_q, r_d;

  // array port
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, mem_rdata;
  logic [MEM_AW-1:0] rw_addr;

  fcs_flash_array u_array (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // address into array: secondary sits above main, low 14 bits offset in main, low 13 bits in secondary
  assign rw_addr = sec_sel ? {3'h4, sec_idx, addr_s2_q[12:0]} : {1'b0, main_idx, addr_s2_q[13:0]};

  // ==========================================
  // decoder and embedded algorithm
  logic [LOW_ADDR_W-1:0] low;
  logic [DATA_W-1:0] cmd;
  logic sel_prot;
  logic busy;
  assign low = addr_s2_q[LOW_ADDR_W-1:0];
  assign cmd = data_s2_q;
  assign sel_prot = main_sel ? main_protect[main_idx] : secondary_protect[sec_idx];
  assign busy = (r_q.st == ST_BUSY_PROG) || (r_q.st == ST_BUSY_ERASE) || (r_q.st == ST_ERA_ACC);

  always_comb begin
    r_d = r_q;
    mem_we = 1'b0;
    mem_addr = rw_addr;
    mem_wdata = r_q.pd;
    r_d.rd_pend = 1'b0;
    // inter-byte time-out while a sequence is partly entered
    if (r_q.st inside {ST_UNL1, ST_UNL2, ST_ERA3, ST_ERA4, ST_ERA5, ST_PROG, ST_BYP_PROG, ST_BYP_EXIT}) begin
      if (r_q.gap >= TMR_W'(TIMEOUT_CYC)) begin
        r_d.st = r_q.bypass ? ST_BYP : ST_READ;
      end else begin
        r_d.gap = r_q.gap + 1'b1;
      end
    end
    if (wr_fall && any_sel && !busy) begin
      r_d.pa = rw_addr;
    end
    if (wr_rise && any_sel && !busy) begin
      r_d.gap = '0;
      if (cmd == CMD_RESET && !r_q.bypass) begin
        r_d.st = ST_READ;
        r_d.err = 1'b0;
      end else begin
        case (r_q.st)
          ST_READ, ST_QUERY: begin
            if (cmd == CMD_UNLOCK1 && low == ADDR_UNLOCK1) begin
              r_d.st = ST_UNL1;
            end else begin
              r_d.st = ST_READ;
            end
            r_d.cursor = '0;
          end
          ST_SUSPEND: begin
            if (cmd == CMD_SECTOR) begin
              r_d.st = ST_BUSY_ERASE;
            end
          end
          ST_UNL1: begin
            r_d.st = (cmd == CMD_UNLOCK2 && low == ADDR_UNLOCK2) ? ST_UNL2 : ST_READ;
          end
          ST_UNL2: begin
            r_d.st = ST_READ;
            if (low == ADDR_UNLOCK1) begin
              if (r_q.cursor == 4'h1 && cmd == CMD_BULK) begin
                r_d.bulk = 1'b1;
                r_d.main_erase = main_sel ? ~main_protect : '0;
                r_d.sec_erase = sec_sel ? ~secondary_protect : '0;
                r_d.tmr = '0;
                r_d.st = ST_BUSY_ERASE;
              end else if (r_q.cursor == 4'h0 && cmd == CMD_ID) begin
                r_d.st = ST_QUERY;
              end else if (r_q.cursor == 4'h0 && cmd == CMD_PROGRAM) begin
                r_d.st = ST_PROG;
              end else if (r_q.cursor == 4'h0 && cmd == CMD_ERASE) begin
                r_d.st = ST_ERA3;
              end else if (r_q.cursor == 4'h0 && cmd == CMD_BYPASS) begin
                r_d.st = ST_BYP;
                r_d.bypass = 1'b1;
              end
            end
            if (r_q.cursor == 4'h1 && cmd == CMD_SECTOR) begin
              r_d.bulk = 1'b0;
              r_d.main_erase = '0;
              r_d.sec_erase = '0;
              if (!sel_prot) begin
                r_d.main_erase = fs_s2_q;
                r_d.sec_erase = cs_s2_q;
              end
              r_d.tmr = '0;
              r_d.st = ST_ERA_ACC;
            end
          end
          ST_ERA3: begin
            r_d.st = (cmd == CMD_UNLOCK1 && low == ADDR_UNLOCK1) ? ST_UNL1 : ST_READ;
            r_d.cursor = 4'h1;
          end
          ST_PROG, ST_BYP_PROG: begin
            r_d.pd = cmd;
            r_d.tmr = '0;
            r_d.ret = r_q.bypass ? ST_BYP : ST_READ;
            r_d.st = sel_prot ? r_d.ret : ST_BUSY_PROG;
          end
          ST_BYP: begin
            if (cmd == CMD_PROGRAM) begin
              r_d.st = ST_BYP_PROG;
            end else if (cmd == CMD_ID) begin
              r_d.st = ST_BYP_EXIT;
            end
          end
          ST_BYP_EXIT: begin
            if (cmd == CMD_BYPASS_EXIT) begin
              r_d.bypass = 1'b0;
              r_d.st = ST_READ;
            end else begin
              r_d.st = ST_BYP;
            end
          end
          default: r_d.st = ST_READ;
        endcase
      end
    end else if (wr_rise && any_sel && busy) begin
      if (r_q.st == ST_ERA_ACC && cmd == CMD_SECTOR) begin
        if (!sel_prot) begin
          r_d.main_erase = r_q.main_erase | fs_s2_q;
          r_d.sec_erase = r_q.sec_erase | cs_s2_q;
        end
        r_d.tmr = '0;
      end else if (r_q.st == ST_BUSY_ERASE && !r_q.bulk && cmd == CMD_SUSPEND) begin
        r_d.st = ST_SUSPEND;
      end
      // other writes while busy are dropped
    end
    // embedded algorithm
    case (r_q.st)
      ST_ERA_ACC: begin
        if (r_q.tmr >= TMR_W'(ADD_SECTOR_WIN_CYC)) begin
          r_d.tmr = '0;
          r_d.cursor = '0;
          r_d.st = ST_BUSY_ERASE;
        end else begin
          r_d.tmr = r_q.tmr + 1'b1;
        end
      end
      ST_BUSY_PROG: begin
        if (r_q.tmr >= TMR_W'(PROGRAM_CYC)) begin
          mem_we = 1'b1;
          mem_addr = r_q.pa;
          mem_wdata = r_q.pd;
          r_d.st = r_q.ret;
        end else begin
          r_d.tmr = r_q.tmr + 1'b1;
        end
      end
      ST_BUSY_ERASE: begin
        if (r_q.tmr >= TMR_W'(ERASE_CYC)) begin
          r_d.st = r_q.bypass ? ST_BYP : ST_READ;
          r_d.main_erase = '0;
          r_d.sec_erase = '0;
        end else begin
          r_d.tmr = r_q.tmr + 1'b1;
        end
      end
      default: ;
    endcase
    // reads: status while busy, query data, FF from a suspended erase sector, else array
    if (rd_fall && any_sel) begin
      r_d.rd_pend = 1'b1;
      r_d.rd_status = busy;
      if (busy) begin
        r_d.toggle = ~r_q.toggle;
      end
    end
    if (r_q.rd_pend) begin
      if (r_q.rd_status) begin
        r_d.rdata = {(r_q.st == ST_BUSY_PROG) ? ~r_q.pd[7] : 1'b0, r_q.toggle, r_q.err, 5'h0};
      end else if (r_q.st == ST_QUERY && low == ADDR_ID && main_sel) begin
        r_d.rdata = MAIN_ID;
      end else if (r_q.st == ST_QUERY && low == ADDR_PROT) begin
        r_d.rdata = sel_prot ? PROT_YES : PROT_NO;
      end else if (r_q.st == ST_SUSPEND && ((main_sel && |(fs_s2_q & r_q.main_erase)) ||
                   (sec_sel && |(cs_s2_q & r_q.sec_erase)))) begin
        r_d.rdata = ERASED_BYTE;
      end else begin
        r_d.rdata = mem_rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus_rdata = r_q.rdata;
  assign ready_busy = !((r_q.st == ST_BUSY_PROG) || (r_q.st == ST_BUSY_ERASE) || (r_q.st == ST_ERA_ACC));
  assign error_flag = r_q.err;
endmodule // fcs_sequencer

// ### design/fcs_pkg.sv
// shared constants and types for the flash command sequencer
package fcs_pkg;
  localparam int MAIN_SECTORS = 8;
  localparam int SEC_SECTORS = 4;
  localparam int ADDR_W = 16;
  localparam int LOW_ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 18;
  // command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  // command addresses (low twelve bits)
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
  localparam logic [11:0] ADDR_ID = 12'h001;
  localparam logic [11:0] ADDR_PROT = 12'h002;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // timing at 40 MHz clock
  localparam int CLK_MHZ = 40;
  localparam int ADD_SECTOR_US = 80;
  localparam int ADD_SECTOR_CYC = ADD_SECTOR_US * CLK_MHZ;
  localparam int CMD_TIMEOUT_CYC = 2000;
  localparam int PROGRAM_CYC = 400;
  localparam int ERASE_SECTOR_CYC = 4000;
  localparam int TMR_W = 16;
  localparam logic [7:0] MAIN_ID_DEFAULT = 8'h5a;

  typedef enum logic [3:0] {
    ST_READ = 4'h0,
    ST_UNL1 = 4'h1,
    ST_UNL2 = 4'h2,
    ST_ERA3 = 4'h3,
    ST_ERA4 = 4'h4,
    ST_ERA5 = 4'h5,
    ST_PROG = 4'h6,
    ST_QUERY = 4'h7,
    ST_ERA_ACC = 4'h8,
    ST_BUSY_PROG = 4'h9,
    ST_BUSY_ERASE = 4'ha,
    ST_SUSPEND = 4'hb,
    ST_BYP = 4'hc,
    ST_BYP_PROG = 4'hd,
    ST_BYP_EXIT = 4'he
  } fcs_state_type;
endpackage

// ### design/fcs_flash_array.sv
// flash array storage: 8-bit words with registered read data
module fcs_flash_array
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // fcs_flash_array

// ### bench/fcs_seq_props.sv
// assertion checker on the flash command sequencer ports
module fcs_seq_props
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_strobe_b,
  input wire logic rd_strobe_b,
  input wire logic [MAIN_SECTORS-1:0] main_sector_select,
  input wire logic [SEC_SECTORS-1:0] secondary_sector_select,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic ready_busy,
  input wire logic error_flag
);
  // ==========================================
  // helper counters
  logic [7:0] since_wr_q;
  logic [7:0] since_rd_q;
  logic [9:0] busy_len_q;
  logic sel_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      since_wr_q <= 8'hff;
      since_rd_q <= 8'hff;
      busy_len_q <= 10'h000;
      sel_q <= 1'b0;
    end else begin
      since_wr_q <= !wr_strobe_b ? 8'h00 : since_wr_q + {7'h00, since_wr_q != 8'hff};
      since_rd_q <= !rd_strobe_b ? 8'h00 : since_rd_q + {7'h00, since_rd_q != 8'hff};
      busy_len_q <= ready_busy ? 10'h000 : busy_len_q + 10'h001;
      sel_q <= !wr_strobe_b ? (|main_sector_select || |secondary_sector_select) : sel_q;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RESET_VALUES: assert property (disable iff (1'b0) !rst_b |=> ready_busy && !error_flag && bus_rdata == 8'h00)
    else $error("outputs not at reset values");
  AST_READY_AFTER_RESET: assert property ($rose(rst_b) |-> ready_busy [*3])
    else $error("busy without a command");
  AST_BUSY_CAUSE: assert property ($fell(ready_busy) |-> since_wr_q <= 8'd8)
    else $error("busy not caused by a write");
  AST_BUSY_SELECT: assert property ($fell(ready_busy) |-> sel_q)
    else $error("busy after unselected write");
  AST_BUSY_HOLD: assert property ($fell(ready_busy) |-> !ready_busy [*8])
    else $error("busy pulse too short");
  AST_BUSY_END: assert property (busy_len_q <= 10'd600)
    else $error("busy never ends");
  AST_RDATA_READ: assert property ($changed(bus_rdata) |-> since_rd_q <= 8'd2)
    else $error("read data changed without a read");
  AST_ERROR_IDLE: assert property (!error_flag)
    else $error("error flag set");
endmodule // fcs_seq_props

bind fcs_sequencer fcs_seq_props u_props (
  .clk(clk),
  .rst_b(rst_b),
  .wr_strobe_b(wr_strobe_b),
  .rd_strobe_b(rd_strobe_b),
  .main_sector_select(main_sector_select),
  .secondary_sector_select(secondary_sector_select),
  .bus_rdata(bus_rdata),
  .ready_busy(ready_busy),
  .error_flag(error_flag)
);

// ### bench/fcs_mcu_model.sv
// bus master model of the microcontroller side
module fcs_mcu_model
  import fcs_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic wr_strobe_b,
  output logic rd_strobe_b,
  output logic [MAIN_SECTORS-1:0] main_sector_select,
  output logic [SEC_SECTORS-1:0] secondary_sector_select,
  input wire logic [DATA_W-1:0] bus_rdata,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_addr = '0;
    bus_wdata = 8'h5a;
    wr_strobe_b = 1'b1;
    rd_strobe_b = 1'b1;
    main_sector_select = '0;
    secondary_sector_select = '0;
    rd_valid = 1'b0;
    rd_data = '0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========================================
  // one write cycle, select held through the strobe
  task automatic wr(input logic [11:0] s, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {secondary_sector_select, main_sector_select} <= s;
    bus_addr <= a;
    bus_wdata <= d;
    idle(3);
    wr_strobe_b <= 1'b0;
    idle(4);
    wr_strobe_b <= 1'b1;
    idle(4);
    {secondary_sector_select, main_sector_select} <= '0;
    bus_wdata <= ~d;
  endtask
  // ==========================================
  // one read cycle, answer taken before release
  task automatic rd(input logic [11:0] s, input logic [15:0] a);
    @(negedge clk);
    {secondary_sector_select, main_sector_select} <= s;
    bus_addr <= a;
    idle(3);
    rd_strobe_b <= 1'b0;
    idle(6);
    rd_data <= bus_rdata;
    rd_valid <= 1'b1;
    idle(1);
    rd_valid <= 1'b0;
    rd_strobe_b <= 1'b1;
    idle(3);
    {secondary_sector_select, main_sector_select} <= '0;
  endtask
endmodule // fcs_mcu_model

// ### bench/testbench.sv
// self-checking bench for the flash command sequencer
module testbench
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3b; // arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [MAIN_SECTORS-1:0] main_protect = '0;
  logic [SEC_SECTORS-1:0] secondary_protect = '0;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata, rd_data, d, t;
  logic wr_strobe_b, rd_strobe_b, ready_busy, error_flag, rd_valid;
  logic [MAIN_SECTORS-1:0] msel;
  logic [SEC_SECTORS-1:0] ssel;
  logic [31:0] lf = 32'hc230;
  logic [15:0] exp_q[$];
  logic [15:0] qe;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #12.5 clk = ~clk;
  fcs_sequencer #(.TIMEOUT_CYC(50), .ADD_SECTOR_WIN_CYC(40), .ERASE_CYC(60), .MAIN_ID(ID)) uut (
    .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .wr_strobe_b(wr_strobe_b), .rd_strobe_b(rd_strobe_b), .main_sector_select(msel),
    .secondary_sector_select(ssel), .main_protect(main_protect),
    .secondary_protect(secondary_protect), .bus_rdata(bus_rdata),
    .ready_busy(ready_busy), .error_flag(error_flag));
  fcs_mcu_model mcu (
    .clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .wr_strobe_b(wr_strobe_b),
    .rd_strobe_b(rd_strobe_b), .main_sector_select(msel), .secondary_sector_select(ssel),
    .bus_rdata(bus_rdata), .rd_valid(rd_valid), .rd_data(rd_data));
  // ==========================================
  // helpers
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [11:0] s, input logic [11:0] a, input logic [7:0] v);
    logic [7:0] r;
    r = rnd();
    mcu.wr(s, {r[3:0], a}, v);
  endtask
  task automatic unl(input logic [11:0] s);
    cmd(s, ADDR_UNLOCK1, CMD_UNLOCK1);
    cmd(s, ADDR_UNLOCK2, CMD_UNLOCK2);
  endtask
  task automatic prog(input logic [11:0] s, input logic [15:0] a, input logic [7:0] v);
    unl(s);
    cmd(s, ADDR_UNLOCK1, CMD_PROGRAM);
    mcu.wr(s, a, v);
  endtask
  task automatic rd(input logic [11:0] s, input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    mcu.rd(s, a);
  endtask
  task automatic rdy(input logic e);
    chk("ready_busy", {7'h00, e}, {7'h00, ready_busy});
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_busy !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    rdy(1'b1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // read result monitor and time limit
  always @(posedge clk) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      qe = exp_q.pop_front();
      chk("bus_rdata", qe[7:0], rd_data & qe[15:8]);
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    mcu.idle(3);
    rdy(1'b1);
    chk("bus_rdata", 8'h00, bus_rdata);
    $display("test reset done");
    d = rnd();
    prog(12'h001, 16'h0123, d);
    rdy(1'b0);
    rd(12'h001, 16'h0123, 8'h80, {~d[7], 7'h00});
    t = rd_data;
    rd(12'h001, 16'h0123, 8'h80, {~d[7], 7'h00});
    chk("toggle_status_bit", {7'h00, ~t[6]}, {7'h00, rd_data[6]});
    cmd(12'h001, 12'h555, CMD_RESET);
    rdy(1'b0);
    wait_rdy();
    rd(12'h001, 16'h0123, 8'hff, d);
    mcu.wr(12'h001, 16'h0123, ~d);
    rd(12'h001, 16'h0123, 8'hff, d);
    $display("test program done");
    t = rnd();
    prog(12'h200, 16'h0040, t);
    wait_rdy();
    rd(12'h200, 16'h0040, 8'hff, t);
    @(negedge clk);
    main_protect[1] = 1'b1;
    secondary_protect[0] = 1'b1;
    prog(12'h002, 16'h0050, t);
    rdy(1'b1);
    prog(12'h100, 16'h0060, t);
    rdy(1'b1);
    $display("test protect done");
    unl(12'h001);
    cmd(12'h001, ADDR_UNLOCK1, CMD_ID);
    rd(12'h001, 16'h0001, 8'hff, ID);
    rd(12'h002, 16'h0002, 8'hff, PROT_YES);
    rd(12'h100, 16'h0002, 8'hff, PROT_YES);
    rd(12'h001, 16'h0002, 8'hff, PROT_NO);
    cmd(12'h001, 12'h7e1, CMD_RESET);
    rd(12'h001, 16'h0123, 8'hff, d);
    $display("test query done");
    for (int k = 0; k < 2; k++) begin
      unl(12'h001);
      if (k == 0) mcu.idle(60);
      else cmd(12'h001, ADDR_UNLOCK1, 8'h77);
      cmd(12'h001, ADDR_UNLOCK1, CMD_PROGRAM);
      mcu.wr(12'h001, 16'h0123, 8'h00);
      rdy(1'b1);
      rd(12'h001, 16'h0123, 8'hff, d);
    end
    $display("test abort done");
    unl(12'h001);
    cmd(12'h001, ADDR_UNLOCK1, CMD_BYPASS);
    t = rnd();
    cmd(12'h001, 12'h3c3, CMD_PROGRAM);
    mcu.wr(12'h001, 16'h0200, t);
    wait_rdy();
    cmd(12'h001, 12'h111, CMD_ID);
    cmd(12'h001, 12'h222, CMD_BYPASS_EXIT);
    rd(12'h001, 16'h0200, 8'hff, t);
    $display("test bypass done");
    unl(12'h004);
    cmd(12'h004, ADDR_UNLOCK1, CMD_ERASE);
    unl(12'h004);
    mcu.wr(12'h004, 16'h0000, CMD_SECTOR);
    rdy(1'b0);
    mcu.idle(45);
    cmd(12'h004, 12'h000, CMD_SUSPEND);
    rd(12'h001, 16'h0123, 8'hff, d);
    rd(12'h004, 16'h0000, 8'hff, ERASED_BYTE);
    cmd(12'h004, 12'h000, CMD_SECTOR);
    wait_rdy();
    unl(12'h001);
    cmd(12'h001, ADDR_UNLOCK1, CMD_ERASE);
    unl(12'h001);
    cmd(12'h001, ADDR_UNLOCK1, CMD_BULK);
    rdy(1'b0);
    wait_rdy();
    $display("test erase done");
    stop_test();
  end
endmodule // testbench
